/* File: core/aeqc_pkg.sv */
// Constants shared by the adaptive equalization control block.
package aeqc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_STAT1 = 8'h3B;
	localparam logic [7:0] ADDR_STAT2 = 8'h3C;
	localparam logic [7:0] ADDR_AUX2 = 8'h51;
	localparam logic [7:0] ADDR_AUX3 = 8'h52;
	localparam logic [7:0] ADDR_CTRL = 8'h60;
	localparam logic [7:0] ADDR_SHORT1 = 8'h61;
	localparam logic [7:0] ADDR_SHORT2 = 8'h62;
	localparam logic [7:0] ADDR_LONG1 = 8'h63;
	localparam logic [7:0] ADDR_LONG2 = 8'h64;
	localparam logic [7:0] ADDR_OVR = 8'h65;
	// Field positions
	localparam int MARGIN_LSB = 5;
	localparam int MARGIN_MSB = 7;
	localparam int FRAC_LSB = 0;
	localparam int FRAC_MSB = 3;
	localparam int MID_LSB = 0;
	localparam int MID_MSB = 3;
	localparam int MERGE_BIT = 4;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_ALG_LSB = 1;
	localparam int CTRL_ALG_MSB = 2;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_MSB = 3;
	localparam int OVR_EN_BIT = 4;
	// Reset values
	localparam logic [2:0] MARGIN_RST = 3'h4;
	localparam logic [3:0] FRAC_RST = 4'h6;
	localparam logic [3:0] MID_RST = 4'h7;
	localparam logic MERGE_RST = 1'b0;
	localparam logic EN_RST = 1'b1;
	localparam logic [1:0] ALG_RST = 2'h2;
	localparam logic [3:0] GAIN_RST = 4'h0;
	localparam logic OVR_EN_RST = 1'b0;
	// Algorithm selections
	localparam logic [1:0] ALG_FAST = 2'h0;
	localparam logic [1:0] ALG_TUNED = 2'h2;
	// Search limits and scale
	localparam logic [3:0] GAIN_MIN = 4'h0;
	localparam logic [3:0] GAIN_MAX = 4'hF;
	localparam logic [3:0] SWING_MIN = 4'h0;
	localparam logic [3:0] SWING_MAX = 4'hF;
	localparam logic [7:0] HIT_SCALE = 8'h80;
	localparam int HIT_SHIFT = 7;
	// Strap level to fixed gain
	localparam logic [3:0] STRAP_GAIN [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
	// Search states
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_CLASSIFY = 6'b000010,
		ST_CENTRE = 6'b000100,
		ST_GAIN = 6'b001000,
		ST_SWING = 6'b010000,
		ST_NEXT = 6'b100000
	} aeqc_state_t;
endpackage

/* File: core/aeqc_thr_if.sv */
// Threshold request and result between search control and calculator.
`timescale 1ns/1ns
`default_nettype none
interface aeqc_thr_if #(parameter int HIT_W = 16);
	logic [HIT_W-1:0] centre_hit_count;
	logic [2:0] margin;
	logic [3:0] fraction;
	logic [HIT_W-1:0] gain_pass_threshold;
	logic [HIT_W-1:0] swing_pass_threshold;
	modport calc (
		input centre_hit_count,
		input margin,
		input fraction,
		output gain_pass_threshold,
		output swing_pass_threshold
	);
	modport user (
		output centre_hit_count,
		output margin,
		output fraction,
		input gain_pass_threshold,
		input swing_pass_threshold
	);
endinterface
`default_nettype wire

/* File: core/aeqc_thresh.sv */
// Hit-count pass thresholds for the gain and swing searches.
`timescale 1ns/1ns
`default_nettype none
module aeqc_thresh #(
	parameter int HIT_W = 16
) (
	// Threshold channel
	aeqc_thr_if.calc thr
);
	import aeqc_pkg::*;

	// Centre count times factor over 128, truncated
	function automatic logic [HIT_W-1:0] scale_hits(
		input logic [HIT_W-1:0] centre,
		input logic [7:0] factor
	);
		logic [HIT_W+7:0] prod;
		prod = {8'h00, centre} * {{HIT_W{1'b0}}, factor};
		scale_hits = prod[HIT_W+HIT_SHIFT-1:HIT_SHIFT];
	endfunction

	assign thr.gain_pass_threshold = scale_hits(thr.centre_hit_count,
		HIT_SCALE - {5'h00, thr.margin});
	assign thr.swing_pass_threshold = scale_hits(thr.centre_hit_count,
		{4'h0, thr.fraction});
endmodule
`default_nettype wire

/* File: core/aeqc_top.sv */
// Adaptive receive equalization control for two connector ports.
// Overview of operation
// - Gain search picks smallest gain with hits at least centre*(128-margin)/128.
// - Swing search picks largest swing with hits at least centre*fraction/128.
// - Gain-search margin is read/write bits 7:5, reset 4.
// - Swing fraction is read/write bits 3:0, reset 6; bit 4 reads zero.
// - Programmed thresholds apply only when algorithm select is binary 10.
// - Full adaptation runs when enabled and algorithm select is 1, 2 or 3.
// - In register mode full adaptation is active after reset.
// - In strap mode the disable strap turns full adaptation off.
// - Fast adaptation runs when enabled and algorithm select is 0.
// - Fast adaptation never runs in strap mode.
// - Fast adaptation classifies channel short or long, then applies stored gain.
// - Short channel applies the per-port short-channel gain registers.
// - Long channel applies the per-port long-channel gain registers.
// - Fixed equalization applies the strap-level gain to both ports in strap mode, each port's short-channel gain in register mode.
// - Per-port status shows full result, fast gain, fixed gain or override value.
// - Centre capture holds the midpoint gain field, reset 7, for select 2 or 3.
`timescale 1ns/1ns
`default_nettype none
module aeqc_top #(
	parameter int HIT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Strap pins
	input wire logic strap_i2c_mode,
	input wire logic adapt_disable_strap,
	input wire logic [1:0] connector_rx_gain_straps,
	// Adaptation trigger
	input wire logic adapt_start,
	// Hit-count measurement
	output logic meas_req,
	output logic meas_port,
	output logic [3:0] meas_gain,
	output logic [3:0] meas_swing,
	input wire logic meas_done,
	input wire logic [HIT_W-1:0] meas_hit_count,
	// Channel classification
	output logic classify_req,
	input wire logic classify_done,
	input wire logic classify_long,
	// Applied settings and status
	output logic [3:0] port1_gain,
	output logic [3:0] port2_gain,
	output logic [3:0] port1_swing,
	output logic [3:0] port2_swing,
	output logic full_active,
	output logic fast_active,
	output logic adapt_busy,
	output logic adapt_done
);
	import aeqc_pkg::*;

	aeqc_thr_if #(.HIT_W(HIT_W)) thr ();
	aeqc_thresh #(.HIT_W(HIT_W)) u_thresh (.thr(thr));

	logic [3:0] strap_s1_reg, strap_s2_reg;
	logic [2:0] gain_search_margin_reg;
	logic [3:0] swing_search_fraction_reg, midpoint_capture_gain_reg;
	logic eq_merge_reg, adapt_enable_bit_reg, ovr_en_reg;
	logic [1:0] adapt_algorithm_select_reg;
	logic [3:0] port1_short_channel_gain_reg, port2_short_channel_gain_reg;
	logic [3:0] port1_long_channel_gain_reg, port2_long_channel_gain_reg;
	logic [3:0] gain_override_field_reg;
	aeqc_state_t state_reg;
	logic wait_reg;
	logic [HIT_W-1:0] centre_hit_count_reg;
	logic [3:0] res_gain1_reg, res_gain2_reg;
	logic i2c_mode, dis_strap, full_en, fast_en, adapt_on, hit_ok_gain;
	logic hit_ok_swing;
	logic [3:0] fixed_gain1, fixed_gain2;

	// Strap synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1_reg <= 4'h0;
			strap_s2_reg <= 4'h0;
		end else begin
			strap_s1_reg <= {strap_i2c_mode, adapt_disable_strap,
				connector_rx_gain_straps};
			strap_s2_reg <= strap_s1_reg;
		end
	end

	assign i2c_mode = strap_s2_reg[3];
	assign dis_strap = strap_s2_reg[2];
	assign full_en = (adapt_algorithm_select_reg != ALG_FAST) &&
		(i2c_mode ? adapt_enable_bit_reg : !dis_strap);
	assign fast_en = i2c_mode && adapt_enable_bit_reg &&
		(adapt_algorithm_select_reg == ALG_FAST);
	assign adapt_on = full_en || fast_en;

	// Register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_search_margin_reg <= MARGIN_RST;
			swing_search_fraction_reg <= FRAC_RST;
			midpoint_capture_gain_reg <= MID_RST;
			eq_merge_reg <= MERGE_RST;
			adapt_enable_bit_reg <= EN_RST;
			adapt_algorithm_select_reg <= ALG_RST;
			port1_short_channel_gain_reg <= GAIN_RST;
			port2_short_channel_gain_reg <= GAIN_RST;
			port1_long_channel_gain_reg <= GAIN_RST;
			port2_long_channel_gain_reg <= GAIN_RST;
			gain_override_field_reg <= GAIN_RST;
			ovr_en_reg <= OVR_EN_RST;
		end else if (reg_wr_en) begin
			case (reg_addr)
				ADDR_AUX3: begin
					gain_search_margin_reg <=
						reg_wdata[MARGIN_MSB:MARGIN_LSB];
					swing_search_fraction_reg <=
						reg_wdata[FRAC_MSB:FRAC_LSB];
				end
				ADDR_AUX2: begin
					midpoint_capture_gain_reg <= reg_wdata[MID_MSB:MID_LSB];
					eq_merge_reg <= reg_wdata[MERGE_BIT];
				end
				ADDR_CTRL: begin
					adapt_enable_bit_reg <= reg_wdata[CTRL_EN_BIT];
					adapt_algorithm_select_reg <=
						reg_wdata[CTRL_ALG_MSB:CTRL_ALG_LSB];
				end
				ADDR_SHORT1: port1_short_channel_gain_reg <=
					reg_wdata[GAIN_MSB:GAIN_LSB];
				ADDR_SHORT2: port2_short_channel_gain_reg <=
					reg_wdata[GAIN_MSB:GAIN_LSB];
				ADDR_LONG1: port1_long_channel_gain_reg <=
					reg_wdata[GAIN_MSB:GAIN_LSB];
				ADDR_LONG2: port2_long_channel_gain_reg <=
					reg_wdata[GAIN_MSB:GAIN_LSB];
				ADDR_OVR: begin
					gain_override_field_reg <= reg_wdata[GAIN_MSB:GAIN_LSB];
					ovr_en_reg <= reg_wdata[OVR_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				ADDR_STAT1: reg_rdata <= {4'h0, port1_gain};
				ADDR_STAT2: reg_rdata <= {4'h0, port2_gain};
				ADDR_AUX2: reg_rdata <= {3'h0, eq_merge_reg,
					midpoint_capture_gain_reg};
				ADDR_AUX3: reg_rdata <= {gain_search_margin_reg, 1'b0,
					swing_search_fraction_reg};
				ADDR_CTRL: reg_rdata <= {5'h00, adapt_algorithm_select_reg,
					adapt_enable_bit_reg};
				ADDR_SHORT1: reg_rdata <= {4'h0, port1_short_channel_gain_reg};
				ADDR_SHORT2: reg_rdata <= {4'h0, port2_short_channel_gain_reg};
				ADDR_LONG1: reg_rdata <= {4'h0, port1_long_channel_gain_reg};
				ADDR_LONG2: reg_rdata <= {4'h0, port2_long_channel_gain_reg};
				ADDR_OVR: reg_rdata <= {3'h0, ovr_en_reg,
					gain_override_field_reg};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Thresholds: programmed only for the tuned algorithm
	assign thr.centre_hit_count = centre_hit_count_reg;
	assign thr.margin = (adapt_algorithm_select_reg == ALG_TUNED) ?
		gain_search_margin_reg : MARGIN_RST;
	assign thr.fraction = (adapt_algorithm_select_reg == ALG_TUNED) ?
		swing_search_fraction_reg : FRAC_RST;
	assign hit_ok_gain = meas_hit_count >= thr.gain_pass_threshold;
	assign hit_ok_swing = meas_hit_count >= thr.swing_pass_threshold;

	// Search sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			wait_reg <= 1'b0;
			meas_req <= 1'b0;
			classify_req <= 1'b0;
			meas_port <= 1'b0;
			meas_gain <= GAIN_MIN;
			meas_swing <= SWING_MAX;
			centre_hit_count_reg <= '0;
			res_gain1_reg <= GAIN_RST;
			res_gain2_reg <= GAIN_RST;
			port1_swing <= SWING_MAX;
			port2_swing <= SWING_MAX;
			adapt_busy <= 1'b0;
			adapt_done <= 1'b0;
		end else begin
			meas_req <= 1'b0;
			classify_req <= 1'b0;
			adapt_done <= 1'b0;
			if (!adapt_on && state_reg != ST_IDLE) begin
				state_reg <= ST_IDLE;
				wait_reg <= 1'b0;
				adapt_busy <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (adapt_start && adapt_on) begin
							meas_port <= 1'b0;
							adapt_busy <= 1'b1;
							state_reg <= ST_NEXT;
						end
					end
					ST_NEXT: begin
						if (fast_en) begin
							state_reg <= ST_CLASSIFY;
						end else begin
							meas_gain <= adapt_algorithm_select_reg[1] ?
								midpoint_capture_gain_reg : MID_RST;
							meas_swing <= SWING_MAX;
							state_reg <= ST_CENTRE;
						end
					end
					ST_CLASSIFY: begin
						if (!wait_reg) begin
							classify_req <= 1'b1;
							wait_reg <= 1'b1;
						end else if (classify_done) begin
							wait_reg <= 1'b0;
							if (!meas_port) begin
								res_gain1_reg <= classify_long ?
									port1_long_channel_gain_reg :
									port1_short_channel_gain_reg;
							end else begin
								res_gain2_reg <= classify_long ?
									port2_long_channel_gain_reg :
									port2_short_channel_gain_reg;
							end
							state_reg <= ST_SWING;
						end
					end
					ST_CENTRE: begin
						if (!wait_reg) begin
							meas_req <= 1'b1;
							wait_reg <= 1'b1;
						end else if (meas_done) begin
							wait_reg <= 1'b0;
							centre_hit_count_reg <= meas_hit_count;
							meas_gain <= GAIN_MIN;
							state_reg <= ST_GAIN;
						end
					end
					ST_GAIN: begin
						if (!wait_reg) begin
							meas_req <= 1'b1;
							wait_reg <= 1'b1;
						end else if (meas_done) begin
							wait_reg <= 1'b0;
							if (hit_ok_gain || meas_gain == GAIN_MAX) begin
								if (!meas_port) begin
									res_gain1_reg <= meas_gain;
								end else begin
									res_gain2_reg <= meas_gain;
								end
								state_reg <= ST_SWING;
							end else begin
								meas_gain <= meas_gain + 4'h1;
							end
						end
					end
					ST_SWING: begin
						if (fast_en) begin
							wait_reg <= 1'b0;
							state_reg <= meas_port ? ST_IDLE : ST_NEXT;
							adapt_busy <= !meas_port;
							adapt_done <= meas_port;
							meas_port <= 1'b1;
						end else if (!wait_reg) begin
							meas_req <= 1'b1;
							wait_reg <= 1'b1;
						end else if (meas_done) begin
							wait_reg <= 1'b0;
							if (hit_ok_swing || meas_swing == SWING_MIN) begin
								if (!meas_port) begin
									port1_swing <= meas_swing;
								end else begin
									port2_swing <= meas_swing;
								end
								state_reg <= meas_port ? ST_IDLE : ST_NEXT;
								adapt_busy <= !meas_port;
								adapt_done <= meas_port;
								meas_port <= 1'b1;
							end else begin
								meas_swing <= meas_swing - 4'h1;
							end
						end
					end
					default: begin
						state_reg <= ST_IDLE;
						wait_reg <= 1'b0;
						adapt_busy <= 1'b0;
					end
				endcase
			end
		end
	end

	// Fixed gain source
	assign fixed_gain1 = i2c_mode ? port1_short_channel_gain_reg :
		STRAP_GAIN[strap_s2_reg[1:0]];
	assign fixed_gain2 = i2c_mode ? port2_short_channel_gain_reg :
		STRAP_GAIN[strap_s2_reg[1:0]];

	// Applied gains and mode flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_gain <= GAIN_RST;
			port2_gain <= GAIN_RST;
			full_active <= 1'b0;
			fast_active <= 1'b0;
		end else begin
			full_active <= full_en;
			fast_active <= fast_en;
			if (ovr_en_reg) begin
				port1_gain <= gain_override_field_reg;
				port2_gain <= gain_override_field_reg;
			end else if (!adapt_on) begin
				port1_gain <= fixed_gain1;
				port2_gain <= fixed_gain2;
			end else begin
				port1_gain <= res_gain1_reg;
				port2_gain <= res_gain2_reg;
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/aeqc_meas_model.sv */
// Far-side hit-count meter and channel classifier model.
`timescale 1ns/1ns
`default_nettype none
module aeqc_meas_model #(
	parameter int HIT_W = 16
) (
	// Clock and reset
	input wire logic clk, rst_n,
	// Behaviour knobs
	input wire logic [3:0] lat, k_gain, k_swing,
	input wire logic long_ch,
	// Requests
	input wire logic meas_req, classify_req,
	input wire logic [3:0] meas_gain, meas_swing,
	// Answers
	output logic meas_done, classify_done, classify_long,
	output logic [HIT_W-1:0] meas_hit_count
);
	int cnt;
	logic cls;
	logic [HIT_W-1:0] hit;
	// Hits rise with gain and fall with swing
	assign hit = HIT_W'(256 + meas_gain * k_gain - meas_swing * k_swing);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			cls <= 1'b0;
			meas_done <= 1'b0;
			classify_done <= 1'b0;
			meas_hit_count <= '0;
			classify_long <= 1'b0;
		end else begin
			if (meas_req || classify_req) begin
				cnt <= 32'(lat) + 1;
				cls <= classify_req;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
			meas_done <= cnt == 1 && !cls;
			classify_done <= cnt == 1 && cls;
			// Outside an answer the data lines do not keep their value
			meas_hit_count <= cnt == 1 ? hit : ~meas_hit_count;
			classify_long <= cnt == 1 ? long_ch : ~classify_long;
		end
	end
endmodule
`default_nettype wire

/* File: bench/aeqc_top_assertions.sv */
// Port-level checks for the adaptive equalization control.
`timescale 1ns/1ns
`default_nettype none
module aeqc_top_chk import aeqc_pkg::*; #(
	parameter int HIT_W = 16
) (
	// Clock, reset and register port
	input wire logic clk, rst_n, reg_wr_en, reg_rd_en,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	// Straps and trigger
	input wire logic strap_i2c_mode, adapt_disable_strap, adapt_start,
	input wire logic [1:0] connector_rx_gain_straps,
	// Measurement and classification
	input wire logic meas_req, meas_port, meas_done, classify_req,
	input wire logic classify_done, classify_long,
	input wire logic [3:0] meas_gain, meas_swing,
	input wire logic [HIT_W-1:0] meas_hit_count,
	// Results
	input wire logic [3:0] port1_gain, port2_gain, port1_swing, port2_swing,
	input wire logic full_active, fast_active, adapt_busy, adapt_done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic go;
	assign go = adapt_start && !adapt_busy;
	property p_rsv_zero;
		reg_rd_en && reg_addr == ADDR_AUX3 |=> !reg_rdata[4];
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bit read as one");
	property p_stat1;
		reg_rd_en && reg_addr == ADDR_STAT1 |=>
			reg_rdata == {4'h0, $past(port1_gain)};
	endproperty
	a_stat1: assert property (p_stat1)
		else $error("status does not show applied gain");
	property p_no_fast;
		!strap_i2c_mode [*5] |-> !fast_active;
	endproperty
	a_no_fast: assert property (p_no_fast)
		else $error("fast adaptation in strap mode");
	property p_excl;
		!(full_active && fast_active);
	endproperty
	a_excl: assert property (p_excl)
		else $error("full and fast both active");
	property p_centre;
		go && full_active |-> ##3 meas_req && meas_swing == SWING_MAX;
	endproperty
	a_centre: assert property (p_centre)
		else $error("centre probe missing");
	property p_classify;
		go && fast_active |-> ##3 classify_req;
	endproperty
	a_classify: assert property (p_classify)
		else $error("classification not requested");
	property p_idle;
		go && !full_active && !fast_active |=> !adapt_busy;
	endproperty
	a_idle: assert property (p_idle)
		else $error("search started while disabled");
	property p_probe;
		meas_req |=> !meas_req && $stable(meas_gain) && $stable(meas_swing);
	endproperty
	a_probe: assert property (p_probe)
		else $error("probe not held");
	property p_end;
		adapt_done |=> !adapt_done && !adapt_busy;
	endproperty
	a_end: assert property (p_end)
		else $error("done not a pulse");
	property p_port;
		adapt_done |-> meas_port;
	endproperty
	a_port: assert property (p_port)
		else $error("run ended before the second port");
	c_full: cover property (go && full_active);
	c_fast: cover property (go && fast_active);
	c_long: cover property (classify_done && classify_long);
endmodule
bind aeqc_top aeqc_top_chk #(.HIT_W(HIT_W)) u_chk (
	.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.strap_i2c_mode(strap_i2c_mode), .adapt_start(adapt_start),
	.adapt_disable_strap(adapt_disable_strap),
	.connector_rx_gain_straps(connector_rx_gain_straps),
	.meas_req(meas_req), .meas_port(meas_port), .meas_done(meas_done),
	.classify_req(classify_req), .classify_done(classify_done),
	.classify_long(classify_long), .meas_gain(meas_gain),
	.meas_swing(meas_swing), .meas_hit_count(meas_hit_count),
	.port1_gain(port1_gain), .port2_gain(port2_gain),
	.port1_swing(port1_swing), .port2_swing(port2_swing),
	.full_active(full_active), .fast_active(fast_active),
	.adapt_busy(adapt_busy), .adapt_done(adapt_done)
);
`default_nettype wire

/* File: bench/tb_aeqc_top.sv */
// Self-checking bench for the adaptive equalization control.
`timescale 1ns/1ns
`default_nettype none
module tb_aeqc_top import aeqc_pkg::*;;
	logic clk, rst_n, wr, rd, i2c, dis, start, lng;
	logic mreq, mport, mdone, creq, cdone, clong, full, fast, busy, done;
	logic [7:0] addr, wdata, rdata;
	logic [1:0] straps;
	logic [3:0] mg, ms, g1, g2, s1, s2, lat, kg, ks;
	logic [15:0] hits;
	int n_fail, samples_checked;
	aeqc_top uut (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr), .reg_rd_en(rd),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.strap_i2c_mode(i2c), .adapt_disable_strap(dis),
		.connector_rx_gain_straps(straps), .adapt_start(start),
		.meas_req(mreq), .meas_port(mport), .meas_gain(mg), .meas_swing(ms),
		.meas_done(mdone), .meas_hit_count(hits), .classify_req(creq),
		.classify_done(cdone), .classify_long(clong), .port1_gain(g1),
		.port2_gain(g2), .port1_swing(s1), .port2_swing(s2),
		.full_active(full), .fast_active(fast), .adapt_busy(busy),
		.adapt_done(done));
	aeqc_meas_model model (.clk(clk), .rst_n(rst_n), .lat(lat), .k_gain(kg),
		.k_swing(ks), .long_ch(lng), .meas_req(mreq), .classify_req(creq),
		.meas_gain(mg), .meas_swing(ms), .meas_done(mdone),
		.classify_done(cdone), .classify_long(clong), .meas_hit_count(hits));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(what, e, rdata);
	endtask
	task automatic gains(input logic [7:0] e1, e2);
		chk("port1_gain", e1, {4'h0, g1});
		chk("port2_gain", e2, {4'h0, g2});
	endtask
	// Start, wait for the end pulse, and count a mismatch if its presence differs from e
	task automatic run(input int lim, input logic [7:0] e);
		repeat (3) @(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (int i = 0; i < lim && !done; i++) @(negedge clk);
		chk("adapt_done", e, {7'h0, done});
		repeat (3) @(negedge clk);
	endtask
	function automatic int hv(int g, int s);
		return 256 + g * kg - s * ks;
	endfunction
	// Smallest passing gain, then largest passing swing
	task automatic exp_full(input int mid, m, f, output logic [7:0] eg, es);
		int c;
		c = hv(mid, 15);
		eg = 8'hF;
		es = 8'h0;
		for (int i = 15; i >= 0; i--)
			if (hv(i, 15) >= c * (128 - m) / 128) eg = 8'(i);
		for (int i = 0; i < 16; i++)
			if (hv(eg, i) >= c * f / 128) es = 8'(i);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// About 20000 cycles, far above the expected run
	initial begin
		#1000000;
		n_fail++;
		end_sim();
	end
	initial begin
		logic [7:0] eg, es;
		{wr, rd, start, dis, lng, rst_n} = '0;
		{addr, wdata, straps, lat} = '0;
		i2c = 1'b1;
		kg = 4'h4;
		ks = 4'hF;
		n_fail = 0;
		samples_checked = 0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("full_active", 8'h01, {7'h0, full});
		rchk("aux3", ADDR_AUX3, 8'h86);
		rchk("aux2", ADDR_AUX2, 8'h07);
		rchk("ctrl", ADDR_CTRL, 8'h05);
		rchk("unmapped", 8'h50, 8'h00);
		wr_reg(ADDR_AUX3, 8'hFF);
		rchk("aux3", ADDR_AUX3, 8'hEF);
		wr_reg(ADDR_AUX3, 8'hEA);
		for (int a = 1; a < 4; a++) begin
			lat = a == 1 ? 4'h0 : 4'h5;
			wr_reg(ADDR_AUX2, a == 2 ? 8'h07 : 8'h05);
			wr_reg(ADDR_CTRL, 8'(a * 2 + 1));
			run(3000, 8'h01);
			exp_full(a == 3 ? 5 : 7, a == 2 ? 7 : 4, a == 2 ? 10 : 6, eg, es);
			gains(eg, eg);
			chk("port1_swing", es, {4'h0, s1});
			chk("port2_swing", es, {4'h0, s2});
			rchk("status1", ADDR_STAT1, eg);
		end
		wr_reg(ADDR_SHORT1, 8'h03);
		wr_reg(ADDR_SHORT2, 8'h04);
		wr_reg(ADDR_LONG1, 8'h09);
		wr_reg(ADDR_LONG2, 8'h0C);
		wr_reg(ADDR_CTRL, 8'h01);
		run(500, 8'h01);
		gains(8'h03, 8'h04);
		lng = 1'b1;
		run(500, 8'h01);
		gains(8'h09, 8'h0C);
		wr_reg(ADDR_CTRL, 8'h00);
		run(20, 8'h00);
		gains(8'h03, 8'h04);
		wr_reg(ADDR_OVR, 8'h1B);
		repeat (2) @(negedge clk);
		gains(8'h0B, 8'h0B);
		rchk("status2", ADDR_STAT2, 8'h0B);
		wr_reg(ADDR_OVR, 8'h0B);
		wr_reg(ADDR_CTRL, 8'h05);
		i2c = 1'b0;
		dis = 1'b1;
		// Strap level 2 selects fixed gain A
		straps = 2'b10;
		repeat (6) @(negedge clk);
		gains(8'h0A, 8'h0A);
		chk("full_active", 8'h00, {7'h0, full});
		dis = 1'b0;
		repeat (6) @(negedge clk);
		chk("full_active", 8'h01, {7'h0, full});
		wr_reg(ADDR_CTRL, 8'h01);
		repeat (3) @(negedge clk);
		chk("fast_active", 8'h00, {7'h0, fast});
		gains(8'h0A, 8'h0A);
		end_sim();
	end
endmodule
`default_nettype wire
